// [sowc_pkg.sv]
`default_nettype none
package sowc_pkg;
  localparam int unsigned ADDR_W   = 32;
  localparam int unsigned WORD_W   = 64;
  localparam int unsigned WORD_B   = 8;
  localparam int unsigned CMB_B    = 16;
  localparam int unsigned CMB_N    = 2;
  localparam int unsigned SB_DEPTH = 4;

  typedef enum logic [3:0] {
    KIND_LOAD                    = 4'h0,
    KIND_STORE                   = 4'h1,
    KIND_LOAD_FENCE_INSTR        = 4'h2,
    KIND_FULL_MEMORY_FENCE_INSTR = 4'h3,
    KIND_STORE_FENCE_INSTR       = 4'h4,
    KIND_IO_LOAD                 = 4'h5,
    KIND_IO_STORE                = 4'h6,
    KIND_LOCKED                  = 4'h7,
    KIND_EXCHANGE_INSTR          = 4'h8,
    KIND_SERIALIZE               = 4'h9,
    KIND_INTERRUPT               = 4'hA
  } sowc_kind_t;

  typedef enum logic [2:0] {
    MT_UNCACHEABLE_TYPE              = 3'h0,
    MT_CACHE_DISABLED_TYPE           = 3'h1,
    MT_WRITE_COMBINING_TYPE          = 3'h2,
    MT_COHERENT_WRITE_COMBINING_TYPE = 3'h3,
    MT_WRITE_PROTECT_TYPE            = 3'h4,
    MT_WRITETHROUGH_TYPE             = 3'h5,
    MT_WRITEBACK_TYPE                = 3'h6
  } sowc_mtype_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUF  = 3'b010,
    ST_ACC  = 3'b100
  } sowc_state_t;
endpackage
`default_nettype wire

// [sowc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module sowc_top #(
  parameter int unsigned AW = sowc_pkg::ADDR_W,
  parameter int unsigned CB = sowc_pkg::CMB_B,
  parameter int unsigned CN = sowc_pkg::CMB_N,
  parameter int unsigned SD = sowc_pkg::SB_DEPTH
) (
  // Clock, reset, enable
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  // Operations from the pipeline, in program order
  input  wire logic                      op_valid,
  output var  logic                      op_ready,
  input  wire sowc_pkg::sowc_kind_t      op_kind,
  input  wire sowc_pkg::sowc_mtype_t     op_mtype,
  input  wire logic                      op_non_temporal_access,
  input  wire logic [AW-1:0]             op_addr,
  input  wire logic [sowc_pkg::WORD_W-1:0] op_wdata,
  input  wire logic [sowc_pkg::WORD_B-1:0] op_be,
  output var  logic                      op_done,
  output var  logic [sowc_pkg::WORD_W-1:0] op_rdata,
  // Memory side
  output var  logic                      mem_req,
  output var  logic                      mem_write,
  output var  logic                      mem_cache,
  output var  logic                      mem_lock,
  output var  logic                      mem_io,
  output var  logic [AW-1:0]             mem_addr,
  output var  logic [CB*8-1:0]           mem_wdata,
  output var  logic [CB-1:0]             mem_be,
  input  wire logic                      mem_ack,
  input  wire logic [CB*8-1:0]           mem_rdata,
  // Status
  output var  logic                      buffers_empty
);
  localparam int unsigned WW  = sowc_pkg::WORD_W;
  localparam int unsigned WB8 = sowc_pkg::WORD_B;
  localparam int unsigned LB  = $clog2(CB);
  localparam int unsigned LW  = CB * 8;
  localparam int unsigned NL  = CB / WB8;
  localparam int unsigned LN  = $clog2(NL);
  localparam int unsigned SP  = $clog2(SD);
  localparam int unsigned CI  = $clog2(CN);
  localparam int unsigned LA  = AW - LB;

  // ---------------------------------------------------------------
  // Held operation
  // ---------------------------------------------------------------
  sowc_pkg::sowc_state_t  state_q;
  sowc_pkg::sowc_kind_t   kind_q;
  sowc_pkg::sowc_mtype_t  mt_q;
  logic                   cur_v_q;
  logic                   nt_q;
  logic [AW-1:0]          addr_q;
  logic [WW-1:0]          data_q;
  logic [WB8-1:0]         be_q;
  logic                   ready_q;
  logic                   done_q;
  logic [WW-1:0]          rdata_q;
  logic                   src_sb_q;
  logic [CI-1:0]          src_idx_q;
  logic [CI-1:0]          victim_q;
  // Store buffer, retired strictly from the head.
  logic [SD-1:0]          sb_v_q;
  logic [AW-1:0]          sb_addr_q [SD];
  logic [WW-1:0]          sb_data_q [SD];
  logic [WB8-1:0]         sb_be_q   [SD];
  logic [SP-1:0]          sb_head_q;
  logic [SP-1:0]          sb_tail_q;
  // Write-combining buffers with per-byte valid flags.
  logic [CN-1:0]          cmb_v_q;
  logic [LA-1:0]          cmb_line_q [CN];
  logic [LW-1:0]          cmb_data_q [CN];
  logic [CB-1:0]          cmb_bv_q   [CN];
  // Memory request registers.
  logic                   req_q;
  logic                   wr_q;
  logic                   cache_q;
  logic                   lock_q;
  logic                   io_q;
  logic [AW-1:0]          maddr_q;
  logic [LW-1:0]          mdata_q;
  logic [CB-1:0]          mbe_q;
  logic                   empty_q;

  // ---------------------------------------------------------------
  // Decode of the held operation
  // ---------------------------------------------------------------
  wire            take     = op_valid & ready_q;
  wire [LA-1:0]   cur_line = addr_q[AW-1:LB];
  wire [LN-1:0]   cur_lane = addr_q[LB-1:3];
  wire            is_ld    = kind_q == sowc_pkg::KIND_LOAD;
  wire            is_st    = kind_q == sowc_pkg::KIND_STORE;
  wire            k_io_ld  = kind_q == sowc_pkg::KIND_IO_LOAD;
  wire            k_io_st  = kind_q == sowc_pkg::KIND_IO_STORE;
  wire            k_lock   = kind_q == sowc_pkg::KIND_LOCKED;
  wire            k_exchange_instr   = kind_q == sowc_pkg::KIND_EXCHANGE_INSTR;
  wire            k_sfen   = kind_q == sowc_pkg::KIND_STORE_FENCE_INSTR;
  wire            k_mfen   = kind_q == sowc_pkg::KIND_FULL_MEMORY_FENCE_INSTR;
  wire            k_ser    = kind_q == sowc_pkg::KIND_SERIALIZE;
  wire            k_irq    = kind_q == sowc_pkg::KIND_INTERRUPT;
  wire            mt_unc   = (mt_q == sowc_pkg::MT_UNCACHEABLE_TYPE) |
                             (mt_q == sowc_pkg::MT_CACHE_DISABLED_TYPE);
  wire            mt_cmb   = (mt_q == sowc_pkg::MT_WRITE_COMBINING_TYPE) |
                             (mt_q == sowc_pkg::MT_COHERENT_WRITE_COMBINING_TYPE);
  wire            mt_cach  = (mt_q == sowc_pkg::MT_WRITE_PROTECT_TYPE) |
                             (mt_q == sowc_pkg::MT_WRITETHROUGH_TYPE) |
                             (mt_q == sowc_pkg::MT_WRITEBACK_TYPE);
  wire            st_cmb   = is_st & !mt_unc & (mt_cmb | nt_q);
  wire            st_cach  = is_st & mt_cach & !nt_q;
  wire            st_unc   = is_st & mt_unc;
  wire            k_heavy  = k_io_ld | k_io_st | k_lock | k_exchange_instr | k_ser | k_irq;
  wire            k_locked = k_lock | k_exchange_instr;
  // ---------------------------------------------------------------
  // Lookups against pending writes
  // ---------------------------------------------------------------
  logic [SD-1:0]  sb_match;
  logic [CN-1:0]  cmb_hit;
  genvar g;
  generate
    for (g = 0; g < SD; g++) begin : g_sb
      assign sb_match[g] = sb_v_q[g] & (sb_addr_q[g][AW-1:LB] == cur_line);
    end
    for (g = 0; g < CN; g++) begin : g_cmb
      assign cmb_hit[g] = cmb_v_q[g] & (cmb_line_q[g] == cur_line);
    end
  endgenerate
  logic [CI-1:0]  hit_idx;
  logic [CI-1:0]  free_idx;
  logic [CI-1:0]  first_idx;
  logic           free_any;
  always_comb begin
    hit_idx   = '0;
    free_idx  = '0;
    first_idx = '0;
    free_any  = 1'b0;
    for (int i = CN - 1; i >= 0; i--) begin
      if (cmb_hit[i]) hit_idx = CI'(i);
      if (cmb_v_q[i]) first_idx = CI'(i);
      if (!cmb_v_q[i]) begin
        free_idx = CI'(i);
        free_any = 1'b1;
      end
    end
  end
  wire sb_any  = |sb_v_q;
  wire sb_full = &sb_v_q;
  wire sb_conf = |sb_match;
  wire cmb_any = |cmb_v_q;
  wire hit_any = |cmb_hit;
  // A load that conflicts with a pending write waits for it rather than
  // forwarding; simpler, and still keeps buffering invisible.
  wire need_drain = k_heavy | k_sfen | k_mfen |
                    (mt_unc & (is_ld | is_st)) |
                    (is_ld & (sb_conf | hit_any)) |
                    (st_cach & hit_any);
  // ---------------------------------------------------------------
  // Action selection
  // ---------------------------------------------------------------
  wire in_idle = state_q == sowc_pkg::ST_IDLE;
  wire blocked = need_drain & (sb_any | cmb_any);
  // Store buffer drains in the background whenever nothing is held.
  wire do_sb   = in_idle & sb_any & (!cur_v_q | blocked | (st_cach & sb_full));
  wire do_cf   = in_idle & !do_sb & cur_v_q &
                 (blocked | (st_cmb & !hit_any & !free_any));
  wire [CI-1:0] cf_idx = blocked ? first_idx : victim_q;
  wire do_ex   = in_idle & cur_v_q & !do_sb & !do_cf;
  wire ex_acc  = do_ex & (is_ld | st_unc | k_io_ld | k_io_st | k_locked);
  wire ex_push = do_ex & st_cach;
  wire ex_mrg  = do_ex & st_cmb;
  wire ex_fin  = do_ex & !ex_acc;
  wire acc_end = (state_q == sowc_pkg::ST_ACC) & mem_ack;
  wire buf_end = (state_q == sowc_pkg::ST_BUF) & mem_ack;
  wire fin     = ex_fin | acc_end;
  wire [CI-1:0] mrg_idx = hit_any ? hit_idx : free_idx;
  // ---------------------------------------------------------------
  // Request formation
  // ---------------------------------------------------------------
  wire [AW-1:0]  hd_addr = sb_addr_q[sb_head_q];
  wire [LN-1:0]  hd_lane = hd_addr[LB-1:3];
  wire [CB-1:0]  hd_be   = {{(CB-WB8){1'b0}}, sb_be_q[sb_head_q]} << {hd_lane, 3'b000};
  wire [CB-1:0]  cur_bes = {{(CB-WB8){1'b0}}, be_q} << {cur_lane, 3'b000};
  wire [LW-1:0]  cur_rep = {NL{data_q}};
  wire           acc_wr  = st_unc | k_io_st | k_locked;
  wire [AW-1:0]  n_addr  = do_sb ? {hd_addr[AW-1:LB], {LB{1'b0}}} :
                           do_cf ? {cmb_line_q[cf_idx], {LB{1'b0}}} :
                                   {cur_line, {LB{1'b0}}};
  wire [LW-1:0]  n_data  = do_sb ? {NL{sb_data_q[sb_head_q]}} :
                           do_cf ? cmb_data_q[cf_idx] : cur_rep;
  wire [CB-1:0]  n_be    = do_sb ? hd_be : do_cf ? cmb_bv_q[cf_idx] : cur_bes;
  // I/O space is never cached, whatever type the pipeline tagged it with.
  wire           n_cache = do_sb | (ex_acc & mt_cach & !(k_io_ld | k_io_st));
  wire           issue   = do_sb | do_cf | ex_acc;
  wire [SP-1:0]  head_nx = (sb_head_q == SP'(SD - 1)) ? '0 : sb_head_q + 1'b1;
  wire [SP-1:0]  tail_nx = (sb_tail_q == SP'(SD - 1)) ? '0 : sb_tail_q + 1'b1;
  // ---------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= sowc_pkg::ST_IDLE;
      cur_v_q <= 1'b0;
      ready_q <= 1'b1;
      done_q  <= 1'b0;
    end else if (ce) begin
      done_q <= fin;
      if (take) begin
        ready_q <= 1'b0;
        cur_v_q <= 1'b1;
      end else if (fin) begin
        ready_q <= 1'b1;
        cur_v_q <= 1'b0;
      end
      case (state_q)
        sowc_pkg::ST_IDLE: begin
          if (do_sb | do_cf) state_q <= sowc_pkg::ST_BUF;
          else if (ex_acc) state_q <= sowc_pkg::ST_ACC;
        end
        sowc_pkg::ST_BUF,
        sowc_pkg::ST_ACC: begin
          if (mem_ack) state_q <= sowc_pkg::ST_IDLE;
        end
        default: state_q <= sowc_pkg::ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      kind_q <= sowc_pkg::KIND_LOAD;
      mt_q   <= sowc_pkg::MT_UNCACHEABLE_TYPE;
      nt_q   <= 1'b0;
      addr_q <= '0;
      data_q <= '0;
      be_q   <= '0;
      rdata_q <= '0;
    end else if (ce) begin
      if (take) begin
        kind_q <= op_kind;
        mt_q   <= op_mtype;
        nt_q   <= op_non_temporal_access;
        addr_q <= op_addr;
        data_q <= op_wdata;
        be_q   <= op_be;
      end
      if (acc_end) rdata_q <= mem_rdata[cur_lane*WW +: WW];
    end
  end
  // Memory request stands until acknowledged.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_q <= 1'b0; wr_q <= 1'b0; cache_q <= 1'b0; lock_q <= 1'b0; io_q <= 1'b0;
      maddr_q <= '0; mdata_q <= '0; mbe_q <= '0;
      src_sb_q <= 1'b0; src_idx_q <= '0; victim_q <= '0; empty_q <= 1'b1;
    end else if (ce) begin
      empty_q <= !sb_any & !cmb_any;
      if (issue) begin
        req_q     <= 1'b1;
        wr_q      <= do_sb | do_cf | acc_wr;
        cache_q   <= n_cache;
        lock_q    <= ex_acc & k_locked;
        io_q      <= ex_acc & (k_io_ld | k_io_st);
        maddr_q   <= n_addr;
        mdata_q   <= n_data;
        mbe_q     <= n_be;
        src_sb_q  <= do_sb;
        src_idx_q <= cf_idx;
      end else if (mem_ack) begin
        req_q <= 1'b0;
      end
      if (do_cf & !blocked) victim_q <= victim_q + 1'b1;
    end
  end
  // ---------------------------------------------------------------
  // Store buffer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sb_v_q    <= '0;
      sb_head_q <= '0;
      sb_tail_q <= '0;
    end else if (ce) begin
      if (ex_push) begin
        sb_v_q[sb_tail_q]    <= 1'b1;
        sb_addr_q[sb_tail_q] <= addr_q;
        sb_data_q[sb_tail_q] <= data_q;
        sb_be_q[sb_tail_q]   <= be_q;
        sb_tail_q            <= tail_nx;
      end
      if (buf_end & src_sb_q) begin
        sb_v_q[sb_head_q] <= 1'b0;
        sb_head_q         <= head_nx;
      end
    end
  end

  // ---------------------------------------------------------------
  // Write-combining buffers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmb_v_q <= '0;
      for (int k = 0; k < CN; k++) cmb_bv_q[k] <= '0;
    end else if (ce) begin
      if (buf_end & !src_sb_q) begin
        cmb_v_q[src_idx_q]  <= 1'b0;
        cmb_bv_q[src_idx_q] <= '0;
      end
      if (ex_mrg) begin
        cmb_v_q[mrg_idx]    <= 1'b1;
        cmb_line_q[mrg_idx] <= cur_line;
        for (int b = 0; b < CB; b++) begin
          if (cur_bes[b]) begin
            cmb_data_q[mrg_idx][b*8 +: 8] <= cur_rep[b*8 +: 8];
            cmb_bv_q[mrg_idx][b]          <= 1'b1;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign op_ready      = ready_q;
  assign op_done       = done_q;
  assign op_rdata      = rdata_q;
  assign mem_req       = req_q;
  assign mem_write     = wr_q;
  assign mem_cache     = cache_q;
  assign mem_lock      = lock_q;
  assign mem_io        = io_q;
  assign mem_addr      = maddr_q;
  assign mem_wdata     = mdata_q;
  assign mem_be        = mbe_q;
  assign buffers_empty = empty_q;
endmodule // sowc_top
`default_nettype wire

// [sowc_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module sowc_chk #(
  parameter int unsigned AW = 32
) (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst_n,
  // Pipeline side
  input wire logic                 ce,
  input wire logic                 op_valid,
  input wire logic                 op_ready,
  input wire sowc_pkg::sowc_kind_t op_kind,
  input wire logic                 op_done,
  // Memory side
  input wire logic                 mem_req,
  input wire logic                 mem_write,
  input wire logic                 mem_cache,
  input wire logic                 mem_lock,
  input wire logic                 mem_io,
  input wire logic [AW-1:0]        mem_addr,
  input wire logic                 mem_ack
);
  sowc_pkg::sowc_kind_t kind_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_take; ce && op_valid && op_ready; endsequence
  sequence s_wait; mem_req && !mem_ack; endsequence
  sequence s_ack; mem_req && mem_ack; endsequence
  always_ff @(posedge clk) if (ce && op_valid && op_ready) kind_q <= op_kind;
  // ---------------------------------------------------------------
  // Handshake and ordering checks
  // ---------------------------------------------------------------
  AST_TAKE_BUSY: assert property (s_take |=> !op_ready && !op_done) else $error("op taken twice");
  AST_DONE_ONE: assert property (op_done |=> !op_done) else $error("done longer than one cycle");
  AST_DONE_READY: assert property (op_done |-> op_ready) else $error("ready not back with done");
  AST_REQ_HOLD: assert property (s_wait |=> mem_req && $stable(mem_addr) && $stable(mem_write))
    else $error("request changed before ack");
  AST_IDLE_AFTER_ACK: assert property (s_ack |=> !mem_req) else $error("no idle after ack");
  AST_LINE_ALIGN: assert property (mem_req |-> mem_addr[3:0] == 4'h0) else $error("unaligned line");
  AST_IO_UNC: assert property (mem_req && mem_io |-> !mem_cache) else $error("io cached");
  AST_LOCK_WR: assert property (mem_req && mem_lock |-> mem_write) else $error("locked not write");
  AST_SER_IDLE: assert property (op_done && kind_q inside {sowc_pkg::KIND_SERIALIZE,
    sowc_pkg::KIND_INTERRUPT, sowc_pkg::KIND_STORE_FENCE_INSTR} |-> !mem_req) else $error("drain open");
endmodule // sowc_chk
bind sowc_top sowc_chk #(.AW(AW)) i_sowc_chk (.clk, .rst_n, .ce, .op_valid, .op_ready, .op_kind,
  .op_done, .mem_req, .mem_write, .mem_cache, .mem_lock, .mem_io, .mem_addr, .mem_ack);
`default_nettype wire

// [sowc_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module sowc_mem (
  // Clock, reset and latency select
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         slow,
  // Memory port
  input  wire logic         mem_req,
  input  wire logic         mem_write,
  input  wire logic         mem_cache,
  input  wire logic [31:0]  mem_addr,
  input  wire logic [127:0] mem_wdata,
  input  wire logic [15:0]  mem_be,
  output logic              mem_ack,
  output logic [127:0]      mem_rdata
);
  logic [7:0]  m [int];
  logic [31:0] log_a [$];
  logic [15:0] log_be [$];
  logic        log_c [$];
  int          cnt;
  function automatic logic [7:0] rd(int a);
    return m.exists(a) ? m[a] : a[7:0] ^ 8'hA5;
  endfunction
  // Read data toggles outside the ack cycle so stale data never looks valid.
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!rst_n) begin
      cnt <= 0;
      mem_rdata <= '0;
    end else if (mem_req && !mem_ack) begin
      if (cnt < (slow ? 3 : 0)) cnt <= cnt + 1;
      else begin
        cnt <= 0;
        mem_ack <= 1'b1;
        for (int i = 0; i < 16; i++) begin
          mem_rdata[i*8 +: 8] <= rd(mem_addr + i);
          if (mem_write && mem_be[i]) m[mem_addr + i] = mem_wdata[i*8 +: 8];
        end
        if (mem_write) begin
          log_a.push_back(mem_addr);
          log_be.push_back(mem_be);
          log_c.push_back(mem_cache);
        end
      end
    end
  end
endmodule // sowc_mem
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam sowc_pkg::sowc_kind_t ST = sowc_pkg::KIND_STORE;
  localparam sowc_pkg::sowc_kind_t SF = sowc_pkg::KIND_STORE_FENCE_INSTR;
  localparam sowc_pkg::sowc_mtype_t WC = sowc_pkg::MT_WRITE_COMBINING_TYPE;
  localparam sowc_pkg::sowc_mtype_t WB = sowc_pkg::MT_WRITEBACK_TYPE;
  logic clk, rst_n, slow, op_valid, nt, op_ready, op_done, mem_req, mem_write, mem_cache;
  logic mem_lock, mem_io, mem_ack, buffers_empty;
  sowc_pkg::sowc_kind_t  kind;
  sowc_pkg::sowc_mtype_t mt;
  logic [31:0]  addr, mem_addr, r;
  logic [31:0]  seed = 32'h4C9C9601;
  logic [63:0]  wd, op_rdata;
  logic [7:0]   be;
  logic [127:0] mem_wdata, mem_rdata;
  logic [15:0]  mem_be;
  logic [7:0]   mm [int];
  int           err_count = 0, tests_run = 0, b;
  sowc_top i_sowc_top (.clk, .rst_n, .ce(1'b1), .op_valid, .op_ready, .op_kind(kind), .op_mtype(mt),
    .op_non_temporal_access(nt), .op_addr(addr), .op_wdata(wd), .op_be(be), .op_done, .op_rdata,
    .mem_req, .mem_write, .mem_cache, .mem_lock, .mem_io, .mem_addr, .mem_wdata, .mem_be, .mem_ack,
    .mem_rdata, .buffers_empty);
  sowc_mem i_sowc_mem (.clk, .rst_n, .slow, .mem_req, .mem_write, .mem_cache, .mem_addr, .mem_wdata,
    .mem_be, .mem_ack, .mem_rdata);
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] rb(int a);
    return mm.exists(a) ? mm[a] : a[7:0] ^ 8'hA5;
  endfunction
  task automatic conclude();
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask
  task automatic lg(input int i, input logic [31:0] a, input logic [15:0] e, input logic c);
    chk({i_sowc_mem.log_a[i], i_sowc_mem.log_be[i], i_sowc_mem.log_c[i]}, {a, e, c}, "write log");
  endtask
  // ---------------------------------------------------------------
  // One operation through the pipeline port, checked against the model
  // ---------------------------------------------------------------
  task automatic op(input sowc_pkg::sowc_kind_t k, input sowc_pkg::sowc_mtype_t t,
                    input logic [31:0] a, input logic [63:0] d, input logic [7:0] e);
    logic [63:0] old;
    int i;
    for (i = 0; i < 8; i++) old[i*8 +: 8] = rb({a[31:3], 3'h0} + i);
    while (op_ready !== 1'b1) begin @(posedge clk); #1; end
    kind = k; mt = t; addr = a; wd = d; be = e; op_valid = 1'b1;
    @(posedge clk); #1;
    op_valid = 1'b0;
    i = 0;
    while (op_done !== 1'b1 && i < 2000) begin @(posedge clk); #1; i++; end
    chk(i < 2000, 1'b1, "no completion");
    if (k inside {sowc_pkg::KIND_LOAD, sowc_pkg::KIND_IO_LOAD, sowc_pkg::KIND_LOCKED,
                  sowc_pkg::KIND_EXCHANGE_INSTR}) chk(op_rdata, old, "read data");
    if (k inside {ST, sowc_pkg::KIND_IO_STORE, sowc_pkg::KIND_LOCKED, sowc_pkg::KIND_EXCHANGE_INSTR})
      for (i = 0; i < 8; i++) if (e[i]) mm[{a[31:3], 3'h0} + i] = d[i*8 +: 8];
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25ns * 40000);
    err_count++;
    conclude();
  end
  initial begin
    rst_n = 0; slow = 0; op_valid = 0; kind = ST; mt = WB; nt = 0; addr = 0; wd = 0; be = 0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1;
    b = i_sowc_mem.log_a.size();
    op(ST, WC, 32'h200, 64'h1111, 8'h0F);
    op(ST, WC, 32'h208, 64'h2222, 8'hF0);
    op(SF, WB, 0, 0, 0);
    chk(i_sowc_mem.log_a.size(), b + 1, "one merged flush");
    lg(b, 32'h200, 16'hF00F, 1'b0);
    slow = 1;
    op(ST, WC, 32'h300, 64'h3333, 8'hFF);
    op(ST, sowc_pkg::MT_UNCACHEABLE_TYPE, 32'h400, 64'h4444, 8'hFF);
    lg(b + 1, 32'h300, 16'h00FF, 1'b0);
    lg(b + 2, 32'h400, 16'h00FF, 1'b0);
    op(ST, WC, 32'h500, 64'h55, 8'h01);
    op(ST, WB, 32'h508, 64'h6666, 8'hFF);
    op(SF, WB, 0, 0, 0);
    lg(b + 3, 32'h500, 16'h0001, 1'b0);
    lg(b + 4, 32'h500, 16'hFF00, 1'b1);
    op(ST, WB, 32'h610, 64'h77, 8'hFF);
    op(sowc_pkg::KIND_INTERRUPT, WB, 0, 0, 0);
    lg(b + 5, 32'h610, 16'h00FF, 1'b1);
    @(posedge clk); #1;
    chk(buffers_empty, 1'b1, "buffers not empty");
    b = i_sowc_mem.log_a.size();
    op(ST, WC, 32'h700, 64'h1, 8'h01);
    op(ST, WC, 32'h800, 64'h2, 8'h01);
    op(ST, WC, 32'h900, 64'h3, 8'h01);
    chk(i_sowc_mem.log_a.size(), b + 1, "range miss flush");
    op(ST, WC, 32'h900, 64'hAB, 8'h01);
    op(SF, WB, 0, 0, 0);
    chk(i_sowc_mem.log_a.size(), b + 3, "fence flush count");
    op(sowc_pkg::KIND_LOAD, WB, 32'h900, 0, 0);
    for (int n = 0; n < 200; n++) begin
      r = xs();
      slow = r[31];
      nt = r[30];
      op(sowc_pkg::sowc_kind_t'(r[27:24] % 11), sowc_pkg::sowc_mtype_t'(r[22:20] % 7),
         r & 32'h78, {xs(), xs()}, r[15:8] | 8'h01);
    end
    op(sowc_pkg::KIND_SERIALIZE, WB, 0, 0, 0);
    for (int a = 0; a < 32'h80; a++) chk(i_sowc_mem.rd(a), rb(a), "memory image");
    conclude();
  end
endmodule // tb
`default_nettype wire
